// *** hw/mrom_result_output_mux.sv ***
// Local design decisions: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/10ps
module mrom_result_output_mux (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [mrom_pkg::ADDR_W-1:0] avsAddress,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [mrom_pkg::DATA_W-1:0] avsWriteData,
	input wire logic [3:0] avsByteEnable,
	output logic [mrom_pkg::DATA_W-1:0] avsReadData,
	output logic avsWaitRequest,
	input wire logic measStart,
	input wire logic measDone,
	input wire logic convDone,
	input wire mrom_pkg::mrom_result_s result,
	input wire logic lowerLimitZero,
	input wire logic screenShown,
	input wire logic errorShown,
	input wire logic settingsBusy,
	input wire logic digitLowSelect,
	output mrom_pkg::mrom_pins_s pins
);

	mrom_pkg::mrom_cfg_s cfg_reg;
	logic [mrom_pkg::GEN_W-1:0] genOut_reg;
	logic wait_reg;
	logic [mrom_pkg::DATA_W-1:0] rdata_reg;
	logic [mrom_pkg::DATA_W-1:0] rdata_next;
	logic end_reg;
	logic conv_reg;
	logic fault_reg;
	logic high_reg;
	logic in_reg;
	logic low_reg;
	logic oob_reg;
	logic [mrom_pkg::NUM_BINS-1:0] bins_reg;
	logic pass_reg;
	logic fail_reg;
	logic terr_reg;
	logic [mrom_pkg::NUM_DIGITS-1:0][mrom_pkg::DIGIT_W-1:0] digit_reg;
	logic [mrom_pkg::RANGE_W-1:0] range_reg;
	logic selMeta_reg;
	logic selSync_reg;
	logic selLow_reg;
	mrom_pkg::mrom_pins_s pins_reg;
	mrom_pkg::mrom_pins_s pins_next;
	logic inputsBlocked;
	logic scanValid;
	logic lowNext;
	logic [mrom_pkg::NUM_DIGITS-1:0][mrom_pkg::DIGIT_W-1:0] digitNext;

	assign avsWaitRequest = wait_reg;
	assign avsReadData = rdata_reg;
	assign pins = pins_reg;
	assign inputsBlocked = !screenShown || errorShown;
	assign scanValid = (cfg_reg.scan == mrom_pkg::SCAN_AUTO) ||
		(cfg_reg.scan == mrom_pkg::SCAN_STEP);

	function automatic logic [mrom_pkg::DIGIT_W-1:0] nibbleOf(
		input logic [mrom_pkg::NUM_DIGITS-1:0][mrom_pkg::DIGIT_W-1:0] d,
		input int idx
	);
		nibbleOf = d[idx];
	endfunction

	// Bus slave: one wait cycle, then the answer stands for one cycle
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			wait_reg <= 1'b1;
		end else if ((avsRead || avsWrite) && wait_reg) begin
			wait_reg <= 1'b0;
		end else begin
			wait_reg <= 1'b1;
		end
	end

	always_comb begin
		rdata_next = '0;
		unique case (avsAddress)
			mrom_pkg::OFF_CONFIG: begin
				rdata_next[mrom_pkg::CFG_BCD] = cfg_reg.bcdMode;
				rdata_next[mrom_pkg::CFG_MUX] = cfg_reg.muxUsed;
				rdata_next[mrom_pkg::CFG_BIN] = cfg_reg.binEnable;
				rdata_next[mrom_pkg::CFG_REFPCT] = cfg_reg.refPercent;
				rdata_next[mrom_pkg::CFG_SCAN_MSB:mrom_pkg::CFG_SCAN_LSB] = cfg_reg.scan;
			end
			mrom_pkg::OFF_GENOUT: rdata_next[mrom_pkg::GEN_W-1:0] = genOut_reg;
			mrom_pkg::OFF_STATUS: begin
				rdata_next[mrom_pkg::ST_END] = end_reg;
				rdata_next[mrom_pkg::ST_CONV] = conv_reg;
				rdata_next[mrom_pkg::ST_FAULT] = fault_reg;
				rdata_next[mrom_pkg::ST_HIGH] = high_reg;
				rdata_next[mrom_pkg::ST_IN] = in_reg;
				rdata_next[mrom_pkg::ST_LOW] = low_reg;
				rdata_next[mrom_pkg::ST_OOB] = oob_reg;
				rdata_next[mrom_pkg::ST_SEL] = selLow_reg;
				rdata_next[mrom_pkg::ST_BUSY] = settingsBusy;
				rdata_next[mrom_pkg::ST_BINS_LSB +: mrom_pkg::NUM_BINS] = bins_reg;
			end
			mrom_pkg::OFF_DIGITS: rdata_next[mrom_pkg::NUM_DIGITS*mrom_pkg::DIGIT_W-1:0] = digit_reg;
			default: rdata_next = '0;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			rdata_reg <= '0;
		end else if (avsRead && wait_reg) begin
			rdata_reg <= rdata_next;
		end
	end

	// Writes with byte enable 0 set land on the edge where waitrequest is seen low; others and unmapped writes vanish
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			cfg_reg <= mrom_pkg::CFG_RESET;
			genOut_reg <= mrom_pkg::GEN_RESET;
		end else if (avsWrite && !wait_reg && avsByteEnable[0]) begin
			if (avsAddress == mrom_pkg::OFF_CONFIG) begin
				cfg_reg.bcdMode <= avsWriteData[mrom_pkg::CFG_BCD];
				cfg_reg.muxUsed <= avsWriteData[mrom_pkg::CFG_MUX];
				cfg_reg.binEnable <= avsWriteData[mrom_pkg::CFG_BIN];
				cfg_reg.refPercent <= avsWriteData[mrom_pkg::CFG_REFPCT];
				cfg_reg.scan <= mrom_pkg::mrom_scan_e'(
					avsWriteData[mrom_pkg::CFG_SCAN_MSB:mrom_pkg::CFG_SCAN_LSB]);
			end
			if (avsAddress == mrom_pkg::OFF_GENOUT) begin
				genOut_reg <= avsWriteData[mrom_pkg::GEN_W-1:0];
			end
		end
	end

	// Select is synchronised, then frozen while inputs are disabled
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			selMeta_reg <= 1'b0;
			selSync_reg <= 1'b0;
			selLow_reg <= 1'b0;
		end else begin
			selMeta_reg <= digitLowSelect;
			selSync_reg <= selMeta_reg;
			if (!inputsBlocked) begin
				selLow_reg <= selSync_reg;
			end
		end
	end

	// End and conversion flags are levels cleared by the next start
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			end_reg <= 1'b0;
			conv_reg <= 1'b0;
		end else begin
			if (measDone) begin
				end_reg <= 1'b1;
			end else if (measStart) begin
				end_reg <= 1'b0;
			end
			if (convDone) begin
				conv_reg <= 1'b1;
			end else if (measStart) begin
				conv_reg <= 1'b0;
			end
		end
	end

	always_comb begin
		lowNext = result.low || (lowerLimitZero && result.negative);
		for (int d = 0; d < mrom_pkg::NUM_DIGITS; d++) begin
			if (result.noReading) begin
				digitNext[d] = mrom_pkg::DIGIT_NINE;
			end else if (result.negative && !cfg_reg.refPercent) begin
				digitNext[d] = mrom_pkg::DIGIT_ZERO;
			end else begin
				digitNext[d] = result.digits[d];
			end
		end
	end

	// Everything is latched on the end event so it is final when the flag rises
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			fault_reg <= 1'b0;
			high_reg <= 1'b0;
			in_reg <= 1'b0;
			low_reg <= 1'b0;
			oob_reg <= 1'b0;
			bins_reg <= '0;
			pass_reg <= 1'b0;
			fail_reg <= 1'b0;
			terr_reg <= 1'b0;
			digit_reg <= '0;
			range_reg <= '0;
		end else if (measDone) begin
			fault_reg <= result.fault;
			high_reg <= result.high && !result.fault;
			in_reg <= result.inBand && !result.fault && !lowNext;
			low_reg <= lowNext && !result.fault;
			bins_reg <= cfg_reg.binEnable ? result.binHit : '0;
			oob_reg <= cfg_reg.binEnable && (result.binHit == '0);
			pass_reg <= result.totalPass;
			fail_reg <= result.totalFail;
			terr_reg <= result.totalErr;
			digit_reg <= digitNext;
			range_reg <= result.range;
		end
	end

	// Line assignment for the current mode
	always_comb begin
		int rb;
		int lb;
		logic [mrom_pkg::DIGIT_W-1:0] nib;
		rb = 0;
		lb = 0;
		nib = '0;
		pins_next = '0;
		pins_next.fault = fault_reg;
		pins_next.measEnd = end_reg;
		pins_next.laneR[mrom_pkg::R_IN] = in_reg;
		if (cfg_reg.bcdMode) begin
			pins_next.line11 = high_reg || low_reg;
			for (int g = 0; g < mrom_pkg::BCD_GROUPS; g++) begin
				if (!selLow_reg) begin
					nib = nibbleOf(digit_reg, mrom_pkg::UPPER_FIRST + g);
				end else if (g == 0) begin
					nib = range_reg;
				end else begin
					nib = nibbleOf(digit_reg, g - 1);
				end
				rb = (g == 0) ? 0 : 2 * g + 1;
				lb = (g == 0) ? 0 : 2 * g;
				pins_next.laneR[rb] = nib[0];
				pins_next.laneL[lb] = nib[1];
				pins_next.laneR[(g == 0) ? 2 : rb + 1] = nib[2];
				pins_next.laneL[(g == 0) ? 1 : lb + 1] = nib[3];
			end
			pins_next.laneR[mrom_pkg::R_IN] = in_reg;
		end else begin
			pins_next.line11 = high_reg;
			pins_next.laneL[mrom_pkg::L_LOW] = low_reg;
			pins_next.laneR[mrom_pkg::R_INDEX] = conv_reg;
			pins_next.laneL[mrom_pkg::L_OUT0] = genOut_reg[0];
			pins_next.laneR[mrom_pkg::R_OUT1] = genOut_reg[1];
			pins_next.laneL[mrom_pkg::L_OUT2] = genOut_reg[2];
			if (cfg_reg.muxUsed) begin
				pins_next.laneL[mrom_pkg::L_PASS] = pass_reg && scanValid;
				pins_next.laneR[mrom_pkg::R_FAIL] = fail_reg && scanValid;
				pins_next.laneL[mrom_pkg::L_TERR] = terr_reg && scanValid;
			end else begin
				pins_next.laneR[mrom_pkg::R_OOB] = oob_reg;
				for (int b = 0; b < mrom_pkg::NUM_BINS / 2; b++) begin
					pins_next.laneL[b + 1] = bins_reg[2 * b];
					pins_next.laneR[b + 3] = bins_reg[2 * b + 1];
				end
			end
		end
	end

	// Lines freeze while settings change rather than show half-updated values
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			pins_reg <= '0;
		end else if (!settingsBusy) begin
			pins_reg <= pins_next;
		end
	end

	property p_end_final;
		@(posedge ref_clk) disable iff (!resetn)
		(measDone && !settingsBusy) ##1 !settingsBusy |=>
			pins_reg.measEnd && (pins_reg.fault == $past(result.fault, 2));
	endproperty
	a_end_final: assert property (p_end_final) else $error("end flag not with fault");

	property p_conv;
		@(posedge ref_clk) disable iff (!resetn)
		convDone |=> conv_reg;
	endproperty
	a_conv: assert property (p_conv) else $error("conversion flag missing");

	property p_fault_same;
		@(posedge ref_clk) disable iff (!resetn)
		!measDone |=> $stable(fault_reg);
	endproperty
	a_fault_same: assert property (p_fault_same) else $error("fault moved off end event");

	property p_fault_judge;
		@(posedge ref_clk) disable iff (!resetn)
		fault_reg |-> !(high_reg || in_reg || low_reg);
	endproperty
	a_fault_judge: assert property (p_fault_judge) else $error("judgment with fault");

	property p_or_line;
		@(posedge ref_clk) disable iff (!resetn)
		(cfg_reg.bcdMode && !settingsBusy) |=> pins_reg.line11 == $past(high_reg || low_reg);
	endproperty
	a_or_line: assert property (p_or_line) else $error("combined judgment wrong");

	property p_totals;
		@(posedge ref_clk) disable iff (!resetn)
		(!cfg_reg.bcdMode && cfg_reg.muxUsed && !scanValid && !settingsBusy) |=>
			!pins_reg.laneL[mrom_pkg::L_PASS] && !pins_reg.laneR[mrom_pkg::R_FAIL];
	endproperty
	a_totals: assert property (p_totals) else $error("totals shown without scan");

	property p_nines;
		@(posedge ref_clk) disable iff (!resetn)
		(measDone && result.noReading) |=> digit_reg == {mrom_pkg::NUM_DIGITS{mrom_pkg::DIGIT_NINE}};
	endproperty
	a_nines: assert property (p_nines) else $error("digits not nine");

	property p_zeros;
		@(posedge ref_clk) disable iff (!resetn)
		(measDone && !result.noReading && result.negative && !cfg_reg.refPercent) |=>
			digit_reg == '0;
	endproperty
	a_zeros: assert property (p_zeros) else $error("negative digits not zero");

	property p_low_zero;
		@(posedge ref_clk) disable iff (!resetn)
		(measDone && !result.fault && lowerLimitZero && result.negative) |=> low_reg && !in_reg;
	endproperty
	a_low_zero: assert property (p_low_zero) else $error("low judgment missing");

	property p_oob;
		@(posedge ref_clk) disable iff (!resetn)
		(measDone && cfg_reg.binEnable) |=> oob_reg == ($past(result.binHit) == '0);
	endproperty
	a_oob: assert property (p_oob) else $error("out-of-bin wrong");

	property p_blocked;
		@(posedge ref_clk) disable iff (!resetn)
		inputsBlocked |=> $stable(selLow_reg);
	endproperty
	a_blocked: assert property (p_blocked) else $error("input taken while disabled");

	property p_switch;
		@(posedge ref_clk) disable iff (!resetn)
		(cfg_reg.bcdMode && $stable(cfg_reg) && !settingsBusy && selLow_reg) |=>
			pins_reg.laneR[0] == $past(range_reg[0]);
	endproperty
	a_switch: assert property (p_switch) else $error("range code not shown");

	property p_gen_out;
		@(posedge ref_clk) disable iff (!resetn)
		(!cfg_reg.bcdMode && !settingsBusy) |=>
			pins_reg.laneR[mrom_pkg::R_OUT1] == $past(genOut_reg[1]);
	endproperty
	a_gen_out: assert property (p_gen_out) else $error("general output wrong");

	property p_mux_unused;
		@(posedge ref_clk) disable iff (!resetn)
		(!cfg_reg.bcdMode && cfg_reg.muxUsed && !settingsBusy) |=>
			!pins_reg.laneR[mrom_pkg::R_OOB] && !pins_reg.laneR[mrom_pkg::R_FAIL + 1];
	endproperty
	a_mux_unused: assert property (p_mux_unused) else $error("unused line driven");

	property p_upper;
		@(posedge ref_clk) disable iff (!resetn)
		(cfg_reg.bcdMode && !settingsBusy && !selLow_reg) |=>
			pins_reg.laneR[0] == $past(digit_reg[mrom_pkg::UPPER_FIRST][0]);
	endproperty
	a_upper: assert property (p_upper) else $error("upper digits not shown");

endmodule

// *** hw/mrom_pkg.sv ***
package mrom_pkg;

	// Avalon-MM register map (byte addresses)
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam logic [3:0] OFF_CONFIG = 4'h0;
	localparam logic [3:0] OFF_GENOUT = 4'h4;
	localparam logic [3:0] OFF_STATUS = 4'h8;
	localparam logic [3:0] OFF_DIGITS = 4'hC;

	// CONFIG field positions
	localparam int CFG_BCD = 0;
	localparam int CFG_MUX = 1;
	localparam int CFG_BIN = 2;
	localparam int CFG_REFPCT = 3;
	localparam int CFG_SCAN_LSB = 4;
	localparam int CFG_SCAN_MSB = 6;

	// STATUS field positions
	localparam int ST_END = 0;
	localparam int ST_CONV = 1;
	localparam int ST_FAULT = 2;
	localparam int ST_HIGH = 3;
	localparam int ST_IN = 4;
	localparam int ST_LOW = 5;
	localparam int ST_OOB = 6;
	localparam int ST_SEL = 7;
	localparam int ST_BUSY = 8;
	localparam int ST_BINS_LSB = 16;

	localparam int NUM_DIGITS = 7;
	localparam int DIGIT_W = 4;
	localparam int NUM_BINS = 10;
	localparam int RANGE_W = 4;
	localparam int GEN_W = 3;
	localparam int LANE_L_W = 8;
	localparam int LANE_R_W = 9;
	localparam int BCD_GROUPS = 4;
	localparam int UPPER_FIRST = 3;

	localparam logic [3:0] DIGIT_NINE = 4'h9;
	localparam logic [3:0] DIGIT_ZERO = 4'h0;

	// Lane slots in judgment mode (laneL index 0 is pin 12, laneR index 0 is pin 29)
	localparam int L_LOW = 0;
	localparam int L_OUT0 = 6;
	localparam int L_OUT2 = 7;
	localparam int L_PASS = 1;
	localparam int L_TERR = 2;
	localparam int R_INDEX = 0;
	localparam int R_IN = 1;
	localparam int R_OOB = 2;
	localparam int R_FAIL = 3;
	localparam int R_OUT1 = 8;

	typedef enum logic [2:0] {
		SCAN_OFF = 3'h1,
		SCAN_AUTO = 3'h2,
		SCAN_STEP = 3'h4
	} mrom_scan_e;

	typedef struct packed {
		logic bcdMode;
		logic muxUsed;
		logic binEnable;
		logic refPercent;
		mrom_scan_e scan;
	} mrom_cfg_s;

	localparam mrom_cfg_s CFG_RESET = '{1'b0, 1'b0, 1'b0, 1'b0, SCAN_OFF};
	localparam logic [2:0] GEN_RESET = 3'h0;

	// Result from the measurement core, valid on measDone
	typedef struct packed {
		logic fault;
		logic high;
		logic inBand;
		logic low;
		logic negative;
		logic noReading;
		logic [NUM_DIGITS-1:0][DIGIT_W-1:0] digits;
		logic [RANGE_W-1:0] range;
		logic [NUM_BINS-1:0] binHit;
		logic totalPass;
		logic totalFail;
		logic totalErr;
	} mrom_result_s;

	// Output lines of the control port
	typedef struct packed {
		logic fault;
		logic line11;
		logic [LANE_L_W-1:0] laneL;
		logic measEnd;
		logic [LANE_R_W-1:0] laneR;
	} mrom_pins_s;

endpackage

// *** dv/mrom_host_model.sv ***
`timescale 1ns/10ps
module mrom_host_model (
	input wire logic ref_clk,
	input wire logic wantLow,
	input wire logic slow,
	input wire logic settingsBusy,
	input wire mrom_pkg::mrom_pins_s pins,
	output logic digitLowSelect,
	output mrom_pkg::mrom_pins_s snap
);
	int waitCnt = 0;
	initial digitLowSelect = 1'b0;
	initial snap = '0;
	// Slow mode makes the select lag the request, like a sluggish controller
	always @(posedge ref_clk) begin
		if (wantLow !== digitLowSelect) begin
			if (!slow || waitCnt == 3) begin
				digitLowSelect <= wantLow;
				waitCnt <= 0;
			end else begin
				waitCnt <= waitCnt + 1;
			end
		end
		// Levels are not trusted while settings change
		if (!settingsBusy) begin
			snap <= pins;
		end
	end
endmodule

// *** dv/test_measurement_result_output_mux.sv ***
`timescale 1ns/10ps
module test_measurement_result_output_mux;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic [3:0] avsAddress = '0;
	logic avsRead = 1'b0;
	logic avsWrite = 1'b0;
	logic [31:0] avsWriteData = '0;
	logic [3:0] avsByteEnable = 4'hF;
	logic [31:0] avsReadData;
	logic avsWaitRequest;
	logic measStart = 1'b0;
	logic measDone = 1'b0;
	logic convDone = 1'b0;
	mrom_pkg::mrom_result_s result = '0;
	logic lowerLimitZero = 1'b0;
	logic screenShown = 1'b1;
	logic errorShown = 1'b0;
	logic settingsBusy = 1'b0;
	logic digitLowSelect;
	logic wantLow = 1'b0;
	logic slow = 1'b0;
	mrom_pkg::mrom_pins_s pins;
	mrom_pkg::mrom_pins_s snap;
	mrom_pkg::mrom_pins_s held;
	mrom_pkg::mrom_result_s cur = '0;
	mrom_pkg::mrom_result_s r;
	int bad_count = 0;
	int checked = 0;
	int cycles = 0;
	logic [7:0] lfsr = 8'h1C;
	logic [31:0] rd;
	logic [6:0] cfg = 7'h10;
	logic [2:0] gen = 3'h5;
	logic endF = 1'b0;
	logic convF = 1'b0;
	logic [6:0] cfgs [7] = '{7'h10, 7'h14, 7'h12, 7'h22, 7'h42, 7'h11, 7'h19};

	always #4 ref_clk = ~ref_clk;

	mrom_result_output_mux i_dut (.ref_clk(ref_clk), .resetn(resetn),
		.avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
		.avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
		.avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
		.measStart(measStart), .measDone(measDone), .convDone(convDone), .result(result),
		.lowerLimitZero(lowerLimitZero), .screenShown(screenShown), .errorShown(errorShown),
		.settingsBusy(settingsBusy), .digitLowSelect(digitLowSelect), .pins(pins));

	mrom_host_model i_host (.ref_clk(ref_clk), .wantLow(wantLow), .slow(slow),
		.settingsBusy(settingsBusy), .pins(pins), .digitLowSelect(digitLowSelect),
		.snap(snap));

	task automatic complete_run();
		if (bad_count == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	function automatic logic [3:0] digit(int i);
		if (cur.noReading) return 4'h9;
		if (cur.negative && !cfg[3]) return 4'h0;
		return cur.digits[i];
	endfunction

	function automatic mrom_pkg::mrom_pins_s expect_pins(logic sel);
		mrom_pkg::mrom_pins_s p;
		logic [3:0] q [4];
		logic hi, inb, lo, tv;
		p = '0;
		hi = cur.high & ~cur.fault;
		lo = (cur.low | (cur.negative & lowerLimitZero)) & ~cur.fault;
		// A part judged low is never also reported in band
		inb = cur.inBand & ~cur.fault & ~lo;
		p.fault = cur.fault;
		p.measEnd = endF;
		p.laneR[1] = inb;
		if (cfg[0]) begin
			p.line11 = hi | lo;
			for (int k = 0; k < 4; k++) begin
				q[k] = sel ? (k == 0 ? cur.range : digit(k - 1)) : digit(k + 3);
				p.laneL[2 * k] = q[k][1];
				p.laneL[2 * k + 1] = q[k][3];
				p.laneR[k == 0 ? 0 : 2 * k + 1] = q[k][0];
				p.laneR[2 * k + 2] = q[k][2];
			end
		end else begin
			p.line11 = hi;
			p.laneL[0] = lo;
			p.laneR[0] = convF;
			p.laneL[6] = gen[0];
			p.laneR[8] = gen[1];
			p.laneL[7] = gen[2];
			tv = cfg[5] | cfg[6];
			if (cfg[1]) begin
				p.laneL[1] = cur.totalPass & tv;
				p.laneR[3] = cur.totalFail & tv;
				p.laneL[2] = cur.totalErr & tv;
			end else if (cfg[2]) begin
				for (int k = 0; k < 5; k++) begin
					p.laneL[k + 1] = cur.binHit[2 * k];
					p.laneR[k + 3] = cur.binHit[2 * k + 1];
				end
				p.laneR[2] = ~|cur.binHit;
			end
		end
		return p;
	endfunction

	task automatic bus(logic wr, logic [3:0] a, logic [31:0] d, logic [3:0] be);
		@(posedge ref_clk);
		avsAddress <= a;
		avsWrite <= wr;
		avsRead <= !wr;
		avsWriteData <= d;
		avsByteEnable <= be;
		do @(posedge ref_clk); while (avsWaitRequest !== 1'b0);
		rd = avsReadData;
		avsRead <= 1'b0;
		avsWrite <= 1'b0;
	endtask

	function automatic logic [7:0] lfsr_step(logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction

	task automatic rand_result();
		r = '0;
		for (int k = 0; k < 7; k++) begin
			lfsr = lfsr_step(lfsr);
			r.digits[k] = 4'(lfsr % 10);
		end
		r.binHit = (lfsr[3:0] < 4'hA) ? 10'(1 << lfsr[3:0]) : 10'h000;
		r.range = 4'(lfsr[7:4] % 12 + 1);
		lfsr = lfsr_step(lfsr);
		{r.fault, r.high, r.inBand, r.low, r.negative, r.noReading, r.totalPass, r.totalFail} = lfsr;
		r.totalErr = lfsr[0] ^ lfsr[7];
		if (r.negative) r.high = 1'b0;
	endtask

	task automatic measure();
		rand_result();
		@(posedge ref_clk);
		measStart <= 1'b1;
		@(posedge ref_clk);
		measStart <= 1'b0;
		convDone <= 1'b1;
		@(posedge ref_clk);
		convDone <= 1'b0;
		measDone <= 1'b1;
		result <= r;
		@(posedge ref_clk);
		measDone <= 1'b0;
		cur = r;
		endF = 1'b1;
		convF = 1'b1;
		@(posedge ref_clk);
		if (!settingsBusy) check("endEarly", pins.measEnd, 1'b0);
		@(posedge ref_clk);
	endtask

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			complete_run();
		end
	end

	initial begin
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		check("resetPins", pins, '0);
		check("resetWait", avsWaitRequest, 1'b1);
		bus(0, mrom_pkg::OFF_CONFIG, 0, 4'hF);
		check("cfgReset", rd, 32'h10);
		bus(0, mrom_pkg::OFF_GENOUT, 0, 4'hF);
		check("genReset", rd, 0);
		bus(1, mrom_pkg::OFF_GENOUT, 32'h5, 4'hF);
		bus(1, mrom_pkg::OFF_GENOUT, 32'h2, 4'hE);
		bus(1, 4'h2, 32'h7F, 4'hF);
		bus(0, 4'h2, 0, 4'hF);
		check("unmapped", rd, 0);
		bus(0, mrom_pkg::OFF_GENOUT, 0, 4'hF);
		check("genout", rd, 32'h5);
		for (int i = 0; i < 7; i++) begin
			cfg = cfgs[i];
			lowerLimitZero <= i[0];
			bus(1, mrom_pkg::OFF_CONFIG, {25'h0, cfg}, 4'hF);
			repeat (6) begin
				measure();
				check("pins", pins, expect_pins(1'b0));
			end
			bus(0, mrom_pkg::OFF_STATUS, 0, 4'hF);
			check("status", rd[2:0], {cur.fault, 2'b11});
			bus(0, mrom_pkg::OFF_DIGITS, 0, 4'hF);
			check("digits", rd, {4'h0, digit(6), digit(5), digit(4), digit(3), digit(2), digit(1),
				digit(0)});
			if (cfg[0]) begin
				slow <= i[1];
				wantLow <= 1'b1;
				repeat (12) @(posedge ref_clk);
				check("lowSel", pins, expect_pins(1'b1));
				errorShown <= 1'b1;
				wantLow <= 1'b0;
				repeat (12) @(posedge ref_clk);
				check("ignored", pins, expect_pins(1'b1));
				errorShown <= 1'b0;
				repeat (12) @(posedge ref_clk);
				check("highSel", pins, expect_pins(1'b0));
			end
		end
		held = pins;
		settingsBusy <= 1'b1;
		measure();
		check("frozen", pins, held);
		check("snap", snap, held);
		settingsBusy <= 1'b0;
		repeat (3) @(posedge ref_clk);
		check("thawed", pins, expect_pins(1'b0));
		complete_run();
	end
endmodule
